//--- uhc_regs.svh
`ifndef UHC_REGS_SVH
`define UHC_REGS_SVH

// ********************************************************************
// Completion code field
// ********************************************************************
`define UHC_CC_W          3
`define UHC_CC_NONE       3'h0
`define UHC_CC_STALL      3'h1
`define UHC_CC_RETRY      3'h2
`define UHC_CC_SHORT      3'h3
`define UHC_CC_LONG       3'h4
`define UHC_CC_STARVED    3'h5

// ********************************************************************
// Limits and timing
// ********************************************************************
// Consecutive retry errors that end a transfer
`define UHC_RETRY_LIMIT   2'h3
// Byte times reserved for token, turnaround and handshake
`define UHC_TOK_OVERHEAD  17'h00040
// Reset value of the per-channel run bits
`define UHC_RUN_RST       1'b0

`endif

//--- uhc_pkg.sv
package uhc_pkg;

    // Transfer kind field encoding
    typedef enum logic [1:0] {
        uhc_kind_bulk = 2'h0,
        uhc_kind_intr = 2'h1,
        uhc_kind_iso  = 2'h2,
        uhc_kind_ctrl = 2'h3
    } uhc_kind_t;

    // Token kind field encoding
    typedef enum logic {
        uhc_tok_out = 1'b0,
        uhc_tok_in  = 1'b1
    } uhc_tok_t;

    // Outcome reported by the packet engine
    typedef enum logic [2:0] {
        uhc_res_ack    = 3'h0,
        uhc_res_nak    = 3'h1,
        uhc_res_stall  = 3'h2,
        uhc_res_none   = 3'h3,
        uhc_res_data   = 3'h4,
        uhc_res_toggle = 3'h5,
        uhc_res_rxerr  = 3'h6,
        uhc_res_sent   = 3'h7
    } uhc_res_t;

    // Engine states, Gray coded along idle-check-wait-finish
    typedef enum logic [1:0] {
        uhc_st_idle   = 2'h0,
        uhc_st_check  = 2'h1,
        uhc_st_wait   = 2'h3,
        uhc_st_finish = 2'h2
    } uhc_state_t;

endpackage

//--- uhc_rr_pick.sv
`timescale 1ns/1ps

// Round-robin picker: offers the next requesting channel after the last one taken
module uhc_rr_pick
    import uhc_pkg::*;
#(
    parameter int N   = 5,
    parameter int CW  = $clog2(N)
)(
    // Clock and reset
    input  wire logic          clock_i,
    input  wire logic          rst_i,
    // Requests and grant
    input  wire logic [N-1:0]  req_i,
    input  wire logic          take_i,
    input  wire logic [CW-1:0] grant_i,
    output logic [CW-1:0]      sel_o,
    output logic               vld_o
);

    typedef struct packed {
        logic [CW-1:0] last;
    } uhc_pick_state_t;

    uhc_pick_state_t s_r;
    uhc_pick_state_t s_nxt;
    int              idx;

    // Search downward so the nearest channel after the last grant wins
    always_comb begin
        s_nxt = s_r;
        sel_o = '0;
        vld_o = 1'b0;
        idx   = 0;
        for (int k = N; k >= 1; k--) begin
            idx = int'(s_r.last) + k;
            if (idx >= N) begin
                idx = idx - N;
            end
            if (req_i[idx]) begin
                sel_o = CW'(idx);
                vld_o = 1'b1;
            end
        end
        if (take_i) begin
            s_nxt.last = grant_i;
        end
    end

    // State register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // uhc_rr_pick

//--- uhc_txn_engine.sv
`timescale 1ns/1ps
`include "uhc_regs.svh"

// Function
// [R1] Pick run channels one at a time, repeat
// [R2] Interrupt OUT checks interval, FIFO data, frame time
// [R3] OUT packet is min of max and remaining
// [R4] OUT ACK sets ack flag, then frees bytes
// [R5] OUT NAK keeps data, resends next selection
// [R6] OUT STALL stops run, stall code, halt
// [R7] OUT no handshake: keep data, retry code, error
// [R8] Three OUT retry errors stop run, halt
// [R9] Iso OUT checks interval, FIFO data, frame time
// [R10] Iso OUT done sets ack, then frees bytes
// [R11] Iso OUT short of data: skip, starved error
// [R12] Bulk IN checks FIFO room and frame time
// [R13] Channel zero is bulk only, no kind field
// [R14] Bulk IN expects min of max and remaining
// [R15] Good bulk IN: ACK, ack flag, commit data
// [R16] Short bulk IN: ACK, commit, stop, short code
// [R17] Bulk IN NAK: no flag, FIFO untouched
// [R18] Bulk IN STALL: stop, stall code, halt
// [R19] Long bulk IN: no ACK, stop, long code
// [R20] Toggle mismatch: ACK, discard, retry error
// [R21] Receive errors: no ACK, discard, retry error
// [R22] Three IN retry errors stop run, halt
// [R23] IN token, endpoint data, host acknowledges
// [R24] Iso OUT: token, data, status, no handshake
// [R25] Failed checks leave channel pending, move on
module uhc_txn_engine
    import uhc_pkg::*;
#(
    parameter int NCH   = 5,
    parameter int MPL_W = 11,
    parameter int LEN_W = 32,
    parameter int IVL_W = 16,
    parameter int LVL_W = 16,
    parameter int CH_W  = $clog2(NCH)
)(
    // Clock and reset
    input  wire logic                             clock_i,
    input  wire logic                             rst_i,
    // Channel control from firmware
    input  wire logic [NCH-1:0]                   run_set_i,
    input  wire logic [NCH-1:0]                   run_clr_i,
    input  wire logic [NCH-1:0][1:0]              transfer_kind_field_i,
    input  wire logic [NCH-1:0]                   token_kind_field_i,
    input  wire logic [NCH-1:0][MPL_W-1:0]        max_packet_length_i,
    input  wire logic [NCH-1:0][LEN_W-1:0]        total_length_i,
    input  wire logic [NCH-1:0][IVL_W-1:0]        interval_i,
    // Event flag clears from firmware
    input  wire logic [NCH-1:0]                   ack_clr_i,
    input  wire logic [NCH-1:0]                   err_clr_i,
    input  wire logic [NCH-1:0]                   halt_clr_i,
    // Frame timing
    input  wire logic                             sof_i,
    input  wire logic [15:0]                      frame_left_i,
    // FIFO levels and updates
    input  wire logic [NCH-1:0][LVL_W-1:0]        fifo_valid_i,
    input  wire logic [NCH-1:0][LVL_W-1:0]        fifo_free_i,
    output logic                                  fifo_release_o,
    output logic                                  fifo_commit_o,
    output logic [CH_W-1:0]                       fifo_ch_o,
    output logic [MPL_W-1:0]                      fifo_count_o,
    // Packet engine
    output logic                                  tok_req_o,
    output uhc_tok_t                              tok_kind_o,
    output uhc_kind_t                             xfer_kind_o,
    output logic [CH_W-1:0]                       tok_ch_o,
    output logic [MPL_W-1:0]                      tok_len_o,
    input  wire logic                             res_valid_i,
    input  uhc_res_t                              res_code_i,
    input  wire logic [MPL_W:0]                   rx_len_i,
    output logic                                  hs_ack_o,
    // Channel status
    output logic [NCH-1:0]                        run_transfer_bit_o,
    output logic [NCH-1:0]                        ack_event_flag_o,
    output logic [NCH-1:0]                        error_event_flag_o,
    output logic [NCH-1:0]                        halt_event_flag_o,
    output logic [NCH-1:0][`UHC_CC_W-1:0]         completion_code_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        uhc_state_t                   st;
        logic [CH_W-1:0]              cur;
        uhc_kind_t                    kind;
        uhc_tok_t                     dir;
        logic [MPL_W-1:0]             len;
        logic                         rel_pend;
        logic                         com_pend;
        logic                         halt_pend;
        logic [MPL_W-1:0]             cnt_pend;
        logic [NCH-1:0]               run;
        logic [NCH-1:0][LEN_W-1:0]    rem;
        logic [NCH-1:0][IVL_W-1:0]    ivl;
        logic [NCH-1:0][1:0]          retry;
        logic [NCH-1:0]               ack;
        logic [NCH-1:0]               err;
        logic [NCH-1:0]               halt;
        logic [NCH-1:0][`UHC_CC_W-1:0] cc;
        logic                         tok_req;
        logic                         hs_ack;
        logic                         rel;
        logic                         com;
    } uhc_eng_state_t;

    uhc_eng_state_t   s_r;
    uhc_eng_state_t   s_nxt;
    logic [CH_W-1:0]  pick_sel;
    logic             pick_vld;
    logic             take;
    uhc_kind_t        ckind;
    uhc_tok_t         cdir;
    logic [MPL_W-1:0] plen;
    logic             frame_ok;
    logic             ivl_due;
    logic             has_data;
    logic             has_room;
    logic             issue_hit;
    logic             starve_hit;
    logic             done_hit;
    logic             retry_hit;

    // ****************************************************************
    // Channel selection and feasibility
    // ****************************************************************
    // Picker sees live run bits; take lands with the latch of cur
    assign take = (s_r.st == uhc_st_idle) && pick_vld && s_r.run[pick_sel]; // R1

    uhc_rr_pick #(
        .N  (NCH),
        .CW (CH_W)
    ) u_pick (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .req_i   (s_r.run),
        .take_i  (take),
        .grant_i (pick_sel),
        .sel_o   (pick_sel),
        .vld_o   (pick_vld)
    );

    // Channel zero ignores its kind field
    assign ckind = (s_r.cur == '0) ? uhc_kind_bulk
                                   : uhc_kind_t'(transfer_kind_field_i[s_r.cur]); // R13
    assign cdir  = uhc_tok_t'(token_kind_field_i[s_r.cur]);

    // Packet length is the smaller of max packet and what is left
    assign plen = (s_r.rem[s_r.cur] < LEN_W'(max_packet_length_i[s_r.cur]))
                ? MPL_W'(s_r.rem[s_r.cur]) : max_packet_length_i[s_r.cur]; // R3 R14

    // Frame budget in byte times, token overhead included
    assign frame_ok = {1'b0, frame_left_i} >= (17'(plen) + `UHC_TOK_OVERHEAD);
    assign ivl_due  = (s_r.ivl[s_r.cur] == '0);
    assign has_data = {1'b0, fifo_valid_i[s_r.cur]} >= (LVL_W+1)'(plen);
    assign has_room = {1'b0, fifo_free_i[s_r.cur]} >= (LVL_W+1)'(plen);

    // Unsupported kind and token pairs are skipped like a failed check
    assign issue_hit = (s_r.st == uhc_st_check) && s_r.run[s_r.cur] && frame_ok
        && (((ckind == uhc_kind_bulk) && (cdir == uhc_tok_in) && has_room) // R12
        || ((ckind == uhc_kind_intr) && (cdir == uhc_tok_out)
            && ivl_due && has_data) // R2
        || ((ckind == uhc_kind_iso) && (cdir == uhc_tok_out)
            && ivl_due && has_data)); // R9
    assign starve_hit = (s_r.st == uhc_st_check) && s_r.run[s_r.cur] && frame_ok
        && (ckind == uhc_kind_iso) && (cdir == uhc_tok_out) && ivl_due && !has_data;

    // Outcome classes while waiting on the packet engine
    assign done_hit  = (s_r.st == uhc_st_wait) && res_valid_i;
    assign retry_hit = done_hit && (s_r.kind != uhc_kind_iso)
        && ((s_r.dir == uhc_tok_out)
            ? !(res_code_i inside {uhc_res_ack, uhc_res_nak, uhc_res_stall}) // R7
            : !(res_code_i inside {uhc_res_data, uhc_res_nak, uhc_res_stall})); // R20 R21

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_nxt         = s_r;
        s_nxt.tok_req = 1'b0;
        s_nxt.hs_ack  = 1'b0;
        s_nxt.rel     = 1'b0;
        s_nxt.com     = 1'b0;
        // Firmware clears first so that any hardware set below wins
        for (int c = 0; c < NCH; c++) begin
            s_nxt.ack[c]  = s_r.ack[c] & ~ack_clr_i[c];
            s_nxt.err[c]  = s_r.err[c] & ~err_clr_i[c];
            s_nxt.halt[c] = s_r.halt[c] & ~halt_clr_i[c];
            if (run_clr_i[c]) begin
                s_nxt.run[c] = 1'b0;
            end
            if (sof_i && (s_r.ivl[c] != '0)) begin
                s_nxt.ivl[c] = s_r.ivl[c] - IVL_W'(1);
            end
        end
        unique case (s_r.st)
            uhc_st_idle: begin
                if (take) begin
                    s_nxt.cur = pick_sel;
                    s_nxt.st  = uhc_st_check;
                end
            end
            uhc_st_check: begin
                s_nxt.st = uhc_st_idle; // R25
                if (issue_hit) begin
                    s_nxt.st      = uhc_st_wait;
                    s_nxt.tok_req = 1'b1; // R23 R24
                    s_nxt.kind    = ckind;
                    s_nxt.dir     = cdir;
                    s_nxt.len     = plen;
                    if (ckind != uhc_kind_bulk) begin
                        s_nxt.ivl[s_r.cur] = interval_i[s_r.cur];
                    end
                end else if (starve_hit) begin
                    s_nxt.err[s_r.cur] = 1'b1; // R11
                    s_nxt.cc[s_r.cur]  = `UHC_CC_STARVED; // R11
                    s_nxt.ivl[s_r.cur] = interval_i[s_r.cur];
                end
            end
            uhc_st_wait: begin
                if (res_valid_i) begin
                    s_nxt.st = uhc_st_finish;
                    if (s_r.kind == uhc_kind_iso) begin
                        // No handshake phase: completion means sent
                        s_nxt.ack[s_r.cur] = 1'b1; // R10 R24
                        s_nxt.rel_pend     = 1'b1;
                        s_nxt.cnt_pend     = s_r.len;
                    end else if (s_r.dir == uhc_tok_out) begin
                        if (res_code_i == uhc_res_ack) begin
                            s_nxt.ack[s_r.cur]   = 1'b1; // R4
                            s_nxt.rel_pend       = 1'b1;
                            s_nxt.cnt_pend       = s_r.len;
                            s_nxt.retry[s_r.cur] = 2'h0;
                        end else if (res_code_i == uhc_res_stall) begin
                            s_nxt.run[s_r.cur] = 1'b0; // R6
                            s_nxt.cc[s_r.cur]  = `UHC_CC_STALL;
                            s_nxt.halt_pend    = 1'b1;
                        end
                    end else begin
                        if (res_code_i == uhc_res_data) begin
                            if (rx_len_i > {1'b0, s_r.len}) begin
                                // Too long: stay silent and drop it
                                s_nxt.run[s_r.cur] = 1'b0; // R19
                                s_nxt.cc[s_r.cur]  = `UHC_CC_LONG;
                                s_nxt.halt_pend    = 1'b1;
                            end else begin
                                s_nxt.hs_ack         = 1'b1; // R15 R23
                                s_nxt.com_pend       = 1'b1;
                                s_nxt.cnt_pend       = MPL_W'(rx_len_i);
                                s_nxt.retry[s_r.cur] = 2'h0;
                                if (rx_len_i < {1'b0, s_r.len}) begin
                                    s_nxt.run[s_r.cur] = 1'b0; // R16
                                    s_nxt.cc[s_r.cur]  = `UHC_CC_SHORT;
                                    s_nxt.halt_pend    = 1'b1;
                                end else begin
                                    s_nxt.ack[s_r.cur] = 1'b1; // R15
                                end
                            end
                        end else if (res_code_i == uhc_res_toggle) begin
                            s_nxt.hs_ack = 1'b1; // R20
                        end else if (res_code_i == uhc_res_stall) begin
                            s_nxt.run[s_r.cur] = 1'b0; // R18
                            s_nxt.cc[s_r.cur]  = `UHC_CC_STALL;
                            s_nxt.halt_pend    = 1'b1;
                        end
                    end
                    // Shared retry path; NAK touches nothing (R5, R17)
                    if (retry_hit) begin
                        s_nxt.cc[s_r.cur]  = `UHC_CC_RETRY; // R7 R21
                        s_nxt.err[s_r.cur] = 1'b1;
                        if (s_r.retry[s_r.cur] == (`UHC_RETRY_LIMIT - 2'h1)) begin
                            s_nxt.run[s_r.cur]   = 1'b0; // R8 R22
                            s_nxt.halt_pend      = 1'b1;
                            s_nxt.retry[s_r.cur] = 2'h0;
                        end else begin
                            s_nxt.retry[s_r.cur] = s_r.retry[s_r.cur] + 2'h1;
                        end
                    end
                end
            end
            uhc_st_finish: begin
                // FIFO moves one cycle after the flags, halt after run clears
                s_nxt.st  = uhc_st_idle;
                s_nxt.rel = s_r.rel_pend; // R4 R10
                s_nxt.com = s_r.com_pend; // R15 R16
                if (s_r.rel_pend || s_r.com_pend) begin
                    s_nxt.rem[s_r.cur] = s_r.rem[s_r.cur] - LEN_W'(s_r.cnt_pend);
                    if (s_r.rem[s_r.cur] == LEN_W'(s_r.cnt_pend)) begin
                        s_nxt.run[s_r.cur] = 1'b0;
                    end
                end
                if (s_r.halt_pend) begin
                    s_nxt.halt[s_r.cur] = 1'b1; // R6 R8 R22
                end
                s_nxt.rel_pend  = 1'b0;
                s_nxt.com_pend  = 1'b0;
                s_nxt.halt_pend = 1'b0;
            end
        endcase
        // A fresh start loads the length and clears history
        for (int c = 0; c < NCH; c++) begin
            if (run_set_i[c]) begin
                s_nxt.run[c]   = 1'b1;
                s_nxt.rem[c]   = total_length_i[c];
                s_nxt.ivl[c]   = '0;
                s_nxt.retry[c] = 2'h0;
            end
        end
    end

    // State register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs, all straight from state
    // ****************************************************************
    assign fifo_release_o     = s_r.rel;
    assign fifo_commit_o      = s_r.com;
    assign fifo_ch_o          = s_r.cur;
    assign fifo_count_o       = s_r.cnt_pend;
    assign tok_req_o          = s_r.tok_req;
    assign tok_kind_o         = s_r.dir;
    assign xfer_kind_o        = s_r.kind;
    assign tok_ch_o           = s_r.cur;
    assign tok_len_o          = s_r.len;
    assign hs_ack_o           = s_r.hs_ack;
    assign run_transfer_bit_o = s_r.run;
    assign ack_event_flag_o   = s_r.ack;
    assign error_event_flag_o = s_r.err;
    assign halt_event_flag_o  = s_r.halt;
    assign completion_code_o  = s_r.cc;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    property p_tok_len;
        issue_hit |=> tok_req_o && (tok_len_o == $past(plen));
    endproperty
    a_tok_len: assert property (p_tok_len) else $error("token length wrong"); // R3

    property p_out_ack;
        (done_hit && s_r.kind == uhc_kind_intr && s_r.dir == uhc_tok_out
         && res_code_i == uhc_res_ack)
        |=> ack_event_flag_o[s_r.cur] && !fifo_release_o
        ##1 fifo_release_o && (fifo_count_o == s_r.len);
    endproperty
    a_out_ack: assert property (p_out_ack) else $error("ack release order"); // R4

    property p_out_nak;
        (done_hit && s_r.dir == uhc_tok_out && s_r.kind == uhc_kind_intr
         && res_code_i == uhc_res_nak) |=> !fifo_release_o [*3];
    endproperty
    a_out_nak: assert property (p_out_nak) else $error("nak freed fifo"); // R5

    property p_stall;
        (done_hit && s_r.kind != uhc_kind_iso && res_code_i == uhc_res_stall
         && !run_set_i[s_r.cur])
        |=> !run_transfer_bit_o[s_r.cur]
            && (completion_code_o[s_r.cur] == `UHC_CC_STALL)
        ##1 halt_event_flag_o[s_r.cur] && !fifo_release_o && !fifo_commit_o;
    endproperty
    a_stall: assert property (p_stall) else $error("stall not halted"); // R6

    property p_retry_limit;
        (retry_hit && s_r.retry[s_r.cur] == 2'h2 && !run_set_i[s_r.cur])
        |=> !run_transfer_bit_o[s_r.cur] && error_event_flag_o[s_r.cur]
        ##1 halt_event_flag_o[s_r.cur];
    endproperty
    a_retry_limit: assert property (p_retry_limit) else $error("retry limit"); // R8

    property p_iso_done;
        (done_hit && s_r.kind == uhc_kind_iso)
        |=> ack_event_flag_o[s_r.cur] && !hs_ack_o ##1 fifo_release_o;
    endproperty
    a_iso_done: assert property (p_iso_done) else $error("iso completion"); // R10

    property p_starve;
        starve_hit |=> !tok_req_o && error_event_flag_o[s_r.cur]
            && (completion_code_o[s_r.cur] == `UHC_CC_STARVED);
    endproperty
    a_starve: assert property (p_starve) else $error("starve not flagged"); // R11

    property p_short;
        (done_hit && s_r.dir == uhc_tok_in && res_code_i == uhc_res_data
         && rx_len_i < {1'b0, s_r.len} && !run_set_i[s_r.cur])
        |=> hs_ack_o && !run_transfer_bit_o[s_r.cur]
        ##1 fifo_commit_o && halt_event_flag_o[s_r.cur];
    endproperty
    a_short: assert property (p_short) else $error("short packet"); // R16

    property p_long;
        (done_hit && s_r.dir == uhc_tok_in && res_code_i == uhc_res_data
         && rx_len_i > {1'b0, s_r.len})
        |=> !hs_ack_o && (completion_code_o[s_r.cur] == `UHC_CC_LONG)
        ##1 !fifo_commit_o && halt_event_flag_o[s_r.cur];
    endproperty
    a_long: assert property (p_long) else $error("long packet"); // R19

    property p_in_nak;
        (done_hit && s_r.dir == uhc_tok_in && res_code_i == uhc_res_nak)
        |=> !hs_ack_o && !fifo_commit_o [*3];
    endproperty
    a_in_nak: assert property (p_in_nak) else $error("nak changed fifo"); // R17

endmodule // uhc_txn_engine

//--- uhc_ep_model.sv
`timescale 1ns/1ps

// ********************************************************************
// Endpoint and packet engine stand-in
// ********************************************************************
module uhc_ep_model
    import uhc_pkg::*;
(
    // Clock and token
    input  wire logic  clock_i,
    input  wire logic  tok_req_i,
    // Answer chosen by the bench
    input  uhc_res_t   code_i,
    input  wire logic [11:0] len_i,
    input  wire logic [3:0]  dly_i,
    // Outcome to the engine
    output logic       res_valid_o,
    output uhc_res_t   res_code_o,
    output logic [11:0] rx_len_o
);
    initial begin
        res_valid_o = 1'b0;
        res_code_o  = uhc_res_none;
        rx_len_o    = 12'h000;
    end
    // One answer per token; fields are scrambled once the pulse ends
    always @(posedge clock_i) begin
        if (tok_req_i) begin
            repeat (dly_i) @(posedge clock_i);
            res_valid_o <= 1'b1;
            res_code_o  <= code_i;
            rx_len_o    <= len_i;
            @(posedge clock_i);
            res_valid_o <= 1'b0;
            res_code_o  <= uhc_res_t'(~code_i);
            rx_len_o    <= ~len_i;
        end
    end
endmodule // uhc_ep_model

//--- uhc_txn_engine_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL %s exp %0h got %0h", n, e, g); end end

module uhc_txn_engine_bench import uhc_pkg::*; ;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] rs = 0, rc = 0, ac = 0, ec = 0, hc = 0, tkf = 5'h01;
    logic [4:0][1:0] kind = {2'h0, 2'h0, 2'h2, 2'h1, 2'h3};
    logic [4:0][10:0] mpl = {5{11'h008}};
    logic [4:0][31:0] tot = {32'h10, 32'h10, 32'h10, 32'h5, 32'h10};
    logic [4:0][15:0] ivl = 0, fv = {16'h0, 16'h0, 16'h4, 16'h40, 16'h0}, ff = {5{16'h40}};
    logic rel, com, hs, tok, rv;
    logic [2:0] fch, tch;
    logic [10:0] fcnt, tlen;
    uhc_tok_t tk;
    uhc_kind_t xk;
    logic [4:0] run, ackf, errf, haltf;
    logic [4:0][2:0] cc;
    uhc_res_t rcode, mcode = uhc_res_data;
    logic [11:0] rl, mlen = 12'h8;
    logic [3:0] mdly = 4'h1;
    int miscompares = 0, num_checks = 0;
    // 125 MHz clock
    always #4 clock_i = ~clock_i;
    uhc_txn_engine dut_u (.clock_i(clock_i), .rst_i(rst_i), .run_set_i(rs), .run_clr_i(rc),
        .transfer_kind_field_i(kind), .token_kind_field_i(tkf), .max_packet_length_i(mpl),
        .total_length_i(tot), .interval_i(ivl), .ack_clr_i(ac), .err_clr_i(ec),
        .halt_clr_i(hc), .sof_i(1'b0), .frame_left_i(16'hffff), .fifo_valid_i(fv),
        .fifo_free_i(ff), .fifo_release_o(rel), .fifo_commit_o(com), .fifo_ch_o(fch),
        .fifo_count_o(fcnt), .tok_req_o(tok), .tok_kind_o(tk), .xfer_kind_o(xk),
        .tok_ch_o(tch), .tok_len_o(tlen), .res_valid_i(rv), .res_code_i(rcode),
        .rx_len_i(rl), .hs_ack_o(hs), .run_transfer_bit_o(run), .ack_event_flag_o(ackf),
        .error_event_flag_o(errf), .halt_event_flag_o(haltf), .completion_code_o(cc));
    uhc_ep_model ep_u (.clock_i(clock_i), .tok_req_i(tok), .code_i(mcode), .len_i(mlen),
        .dly_i(mdly), .res_valid_o(rv), .res_code_o(rcode), .rx_len_o(rl));

    task cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task final_report;
        if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Lands one step after the edge that takes the outcome
    task wait_res;
        int i;
        for (i = 0; i < 60 && rv !== 1'b1; i++) cyc(1);
        if (rv !== 1'b1) begin miscompares++; final_report; end
        cyc(1);
    endtask
    task start(input int c);
        rs[c] = 1'b1; hc[c] = 1'b1; ec[c] = 1'b1;
        cyc(1);
        rs = 0; hc = 0; ec = 0;
    endtask
    // Good, short then long bulk IN packets on the bulk-only channel
    task t_bulk;
        int k;
        mcode = uhc_res_nak; start(0); wait_res;
        `CHK("inak", 3'h0, {hs, ackf[0], errf[0]})
        mcode = uhc_res_data; wait_res;
        `CHK("len", 11'h8, tlen)
        `CHK("tki", 3'h4, {tk, xk})
        `CHK("hs", 1'b1, hs)
        `CHK("ack", 1'b1, ackf[0])
        mlen = 12'h5; cyc(1);
        `CHK("cnt", 11'h8, fcnt)
        wait_res;
        `CHK("shs", 1'b1, hs)
        `CHK("src", 3'h3, cc[0])
        `CHK("srun", 1'b0, run[0])
        cyc(1);
        `CHK("scom", 11'h5, fcnt)
        `CHK("shlt", 1'b1, haltf[0])
        mlen = 12'h9; start(0); wait_res;
        `CHK("lhs", 1'b0, hs)
        `CHK("lcc", 3'h4, cc[0])
        cyc(1);
        `CHK("lcom", 1'b0, com)
        `CHK("lhlt", 1'b1, haltf[0])
        // Toggle, receive error, toggle: ACK only on toggle, third one halts
        mcode = uhc_res_toggle; start(0);
        for (k = 0; k < 3; k++) begin
            wait_res;
            `CHK("ehs", {~k[0], 1'b1}, {hs, errf[0]})
            mcode = k[0] ? uhc_res_toggle : uhc_res_rxerr;
        end
        `CHK("erun", 1'b0, run[0])
    endtask
    // Interrupt OUT: three retry errors, a stall, then an acknowledged packet
    task t_intr;
        int k;
        mcode = uhc_res_none; mdly = 4'h6; start(1);
        for (k = 0; k < 3; k++) begin
            wait_res;
            `CHK("rcc", 3'h2, cc[1])
            `CHK("rerr", 1'b1, errf[1])
        end
        `CHK("rrun", 1'b0, run[1])
        cyc(1);
        `CHK("rhlt", 1'b1, haltf[1])
        mcode = uhc_res_stall; start(1); wait_res;
        `CHK("stc", 3'h1, cc[1])
        `CHK("str", 1'b0, run[1])
        cyc(1);
        `CHK("sth", 1'b1, haltf[1])
        `CHK("stf", 1'b0, rel)
        mcode = uhc_res_nak; start(1); wait_res;
        `CHK("onak", 2'h0, {ackf[1], errf[1]})
        mcode = uhc_res_ack; wait_res;
        `CHK("oack", 1'b1, ackf[1])
        cyc(1);
        `CHK("orel", 11'h5, rel ? fcnt : 11'h0)
    endtask
    // Isochronous OUT starved first, then sent once data arrives
    task t_iso;
        mcode = uhc_res_sent; mdly = 4'h1; start(2); cyc(6);
        `CHK("icc", 3'h5, cc[2])
        `CHK("ierr", 1'b1, errf[2])
        fv[2] = 16'h10; wait_res;
        `CHK("iack", 1'b1, ackf[2])
        `CHK("ihs", 1'b0, hs)
        cyc(1);
        `CHK("irel", 1'b1, rel)
        `CHK("ich", 6'h12, {tch, fch})
    endtask

    initial begin
        cyc(6);
        rst_i = 1'b0;
        t_bulk;
        t_intr;
        t_iso;
        final_report;
    end
endmodule // uhc_txn_engine_bench
